// file: hw/egp_pkg.sv
// Package for the eight-bit GPIO port with analog channel sharing.
// Assumes an AXI4-Lite register bus with 32-bit data.
package egp_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // Printed offset is not a multiple of four, so it is kept as an index
    localparam logic [11:0] EGP_IDX_LATCH = 12'h441;
    localparam logic [11:0] EGP_IDX_DIR = 12'h442;
    localparam logic [11:0] EGP_IDX_ADC = 12'h443;
    localparam logic [13:0] EGP_ADDR_LATCH = {EGP_IDX_LATCH, 2'b00};
    localparam logic [13:0] EGP_ADDR_DIR = {EGP_IDX_DIR, 2'b00};
    localparam logic [13:0] EGP_ADDR_ADC = {EGP_IDX_ADC, 2'b00};
    localparam int EGP_AW = 14;
    localparam logic [7:0] EGP_DIR_RST = 8'h00;
    localparam logic [1:0] EGP_RESP_OKAY = 2'b00;
    localparam logic [1:0] EGP_RESP_SLVERR = 2'b10;
    // ADC select register: bit 3 enable, bits 2:0 pin number
    localparam int EGP_ADC_EN_BIT = 3;
    localparam logic [3:0] EGP_ADC_RST = 4'h0;

    typedef struct packed {
        logic [7:0] out_val;
        logic [7:0] out_en;
        logic [7:0] analog_sel;
    } egp_pin_drive_t;

    typedef enum logic [1:0] {
        EGP_W_IDLE = 2'b00,
        EGP_W_RESP = 2'b01
    } egp_wstate_t;
endpackage

// file: hw/egp_port.sv
// Eight-bit GPIO port with data latch, direction register and analog takeover.
// Assumes an AXI4-Lite master on core_clk and pins asynchronous to it.
//
// Behaviour
// - Eight readable and writable data latches in one byte-wide register.
// - Reset leaves the data latches untouched.
// - Direction bit 1 enables the pin driver, 0 makes it an input.
// - Reset clears all direction bits, so every pin is an input.
// - Data read returns latch where direction is 1, pin level where 0.
// - Latch writes with strobe bit 0 set always land, regardless of direction.
// - Converter-selected pin loses digital drive and goes to analog.
// - Unselected pins behave as ordinary digital pins.
`timescale 1ns/10ps
module egp_port
    import egp_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic rst_b, // Sync reset, active low
    input wire logic [EGP_AW-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [EGP_AW-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [7:0] pin_in, // Pin levels
    output logic [7:0] pin_out, // Pin drive values
    output logic [7:0] pin_oe, // Pin driver enables
    output logic [7:0] analog_sel // Pin routed to converter
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] latch_reg, latch_next;
    logic [7:0] dir_reg, dir_next;
    logic [3:0] adc_reg, adc_next;
    logic [7:0] sync1_reg, sync2_reg, sync3_reg, pin_lvl_reg, pin_lvl_next;
    egp_pin_drive_t drv_reg, drv_next;
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [EGP_AW-1:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    egp_wstate_t wst_reg, wst_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic awready_reg, awready_next, wready_reg, wready_next, bvalid_reg, bvalid_next;
    logic arready_reg, arready_next;

    function automatic logic [7:0] egp_onehot(input logic [3:0] sel);
        egp_onehot = sel[EGP_ADC_EN_BIT] ? (8'h01 << sel[2:0]) : 8'h00;
    endfunction

    function automatic logic egp_hit(input logic [EGP_AW-1:0] a, input logic [EGP_AW-1:0] r);
        egp_hit = (a[EGP_AW-1:2] == r[EGP_AW-1:2]);
    endfunction

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        wst_next = wst_reg;
        bresp_next = bresp_reg;
        latch_next = latch_reg;
        dir_next = dir_reg;
        adc_next = adc_reg;
        if (s_axi_awvalid && !aw_have_reg && wst_reg == EGP_W_IDLE) begin
            aw_have_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_reg && wst_reg == EGP_W_IDLE) begin
            w_have_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        unique case (wst_reg)
            EGP_W_IDLE: begin
                if (aw_have_reg && w_have_reg) begin
                    bresp_next = EGP_RESP_OKAY;
                    if (egp_hit(awaddr_reg, EGP_ADDR_LATCH)) begin
                        if (wstrb_reg[0]) latch_next = wdata_reg[7:0];
                    end else if (egp_hit(awaddr_reg, EGP_ADDR_DIR)) begin
                        if (wstrb_reg[0]) dir_next = wdata_reg[7:0];
                    end else if (egp_hit(awaddr_reg, EGP_ADDR_ADC)) begin
                        if (wstrb_reg[0]) adc_next = wdata_reg[3:0];
                    end else begin
                        bresp_next = EGP_RESP_SLVERR;
                    end
                    aw_have_next = 1'b0;
                    w_have_next = 1'b0;
                    wst_next = EGP_W_RESP;
                end
            end
            EGP_W_RESP: begin
                if (s_axi_bready) wst_next = EGP_W_IDLE;
            end
        endcase
        // Handshake outputs registered from the next state, so they match the held flags
        awready_next = !aw_have_next && wst_next == EGP_W_IDLE;
        wready_next = !w_have_next && wst_next == EGP_W_IDLE;
        bvalid_next = (wst_next == EGP_W_RESP);
    end

    // Latch has no reset branch: its contents survive reset
    always_ff @(posedge core_clk) begin
        latch_reg <= latch_next;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dir_reg <= EGP_DIR_RST;
            adc_reg <= EGP_ADC_RST;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            wst_reg <= EGP_W_IDLE;
            bresp_reg <= EGP_RESP_OKAY;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
        end else begin
            dir_reg <= dir_next;
            adc_reg <= adc_next;
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            wst_reg <= wst_next;
            bresp_reg <= bresp_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ------------------------------------------------------------
    // Pin synchroniser and read channel
    // ------------------------------------------------------------
    // Level changes count once the second and third stages agree
    always_comb begin
        pin_lvl_next = pin_lvl_reg;
        for (int i = 0; i < 8; i++) begin
            if (sync2_reg[i] == sync3_reg[i]) pin_lvl_next[i] = sync3_reg[i];
        end
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready) rvalid_next = 1'b0;
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next = EGP_RESP_OKAY;
            rdata_next = 32'h0000_0000;
            if (egp_hit(s_axi_araddr, EGP_ADDR_LATCH))
                rdata_next[7:0] = (dir_reg & latch_reg) | (~dir_reg & pin_lvl_reg);
            else if (egp_hit(s_axi_araddr, EGP_ADDR_DIR))
                rdata_next[7:0] = dir_reg;
            else if (egp_hit(s_axi_araddr, EGP_ADDR_ADC))
                rdata_next[3:0] = adc_reg;
            else
                rresp_next = EGP_RESP_SLVERR;
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge core_clk) begin
        sync1_reg <= pin_in;
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
        if (!rst_b) begin
            pin_lvl_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= EGP_RESP_OKAY;
            arready_reg <= 1'b1;
        end else begin
            pin_lvl_reg <= pin_lvl_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            arready_reg <= arready_next;
        end
    end

    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_comb begin
        drv_next.analog_sel = egp_onehot(adc_reg);
        drv_next.out_en = dir_reg & ~drv_next.analog_sel;
        drv_next.out_val = latch_reg & drv_next.out_en;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            drv_reg <= '0;
        end else begin
            drv_reg <= drv_next;
        end
    end

    assign pin_out = drv_reg.out_val;
    assign pin_oe = drv_reg.out_en;
    assign analog_sel = drv_reg.analog_sel;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_RESET_DIR: assert property (@(posedge core_clk) !rst_b |=> dir_reg == 8'h00)
        else $error("direction not cleared by reset");
    AST_OE_FOLLOWS_DIR: assert property (@(posedge core_clk) disable iff (!rst_b)
        adc_reg == 4'h0 |=> pin_oe == $past(dir_reg))
        else $error("driver enable does not follow direction");
    AST_ANALOG_OVERRIDE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pin_oe & analog_sel) == 8'h00)
        else $error("analog pin still driven");
    AST_READ_MUX: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_axi_arvalid && !rvalid_reg && egp_hit(s_axi_araddr, EGP_ADDR_LATCH)
        |=> s_axi_rvalid && s_axi_rdata[7:0] == (($past(dir_reg) & $past(latch_reg))
            | (~$past(dir_reg) & $past(pin_lvl_reg))))
        else $error("data read mux wrong");
    sequence egp_latch_write_s;
        wst_reg == EGP_W_IDLE && aw_have_reg && w_have_reg && wstrb_reg[0]
            && egp_hit(awaddr_reg, EGP_ADDR_LATCH);
    endsequence
    AST_LATCH_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b)
        egp_latch_write_s |=> latch_reg == $past(wdata_reg[7:0]))
        else $error("latch write lost");
    AST_SYNC_AGREE: assert property (@(posedge core_clk) disable iff (!rst_b)
        sync2_reg == sync3_reg |=> pin_lvl_reg == $past(sync3_reg))
        else $error("pin level not taken after agreement");
    AST_BRESP_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_LATCH_STABLE: assert property (@(posedge core_clk) disable iff (!rst_b)
        !(wst_reg == EGP_W_IDLE && aw_have_reg && w_have_reg) |=> $stable(latch_reg))
        else $error("latch changed without a write");
endmodule

// file: verification/egp_pin_model.sv
// Far-side model: package pins plus the converter's input mux.
// Assumes the port drives push-pull while enabled; ext_lvl sets all other pins.
`timescale 1ns/10ps
module egp_pin_model
(
    input wire logic [7:0] pin_out, // Port drive values
    input wire logic [7:0] pin_oe, // Port driver enables
    input wire logic [7:0] analog_sel, // Converter pick
    input wire logic [7:0] ext_lvl, // Level applied from outside
    output logic [7:0] pin_in // Level seen at the pins
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // A converter-held pin carries the outside level, never the port drive
            pin_in[i] = (pin_oe[i] && !analog_sel[i]) ? pin_out[i] : ext_lvl[i];
        end
    end
endmodule

// file: verification/test_eight_bit_gpio_port_with_adc_share.sv
// Self-checking bench for the GPIO port: AXI4-Lite tasks and register tests.
// Assumes egp_pkg compiled first and the pin model on the far side.
`timescale 1ns/10ps
module test_eight_bit_gpio_port_with_adc_share;
    import egp_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [EGP_AW-1:0] s_axi_awaddr = '0;
    logic [EGP_AW-1:0] s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic [7:0] pin_in, pin_out, pin_oe, analog_sel;
    logic [7:0] ext_lvl = 8'h00;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;

    egp_port i_egp_port (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pin_in, .pin_out, .pin_oe, .analog_sel);
    egp_pin_model i_egp_pin_model (.pin_out, .pin_oe, .analog_sel, .ext_lvl, .pin_in);

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axw(input logic [EGP_AW-1:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [EGP_AW-1:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rchk(input logic [EGP_AW-1:0] a, input logic [31:0] exp);
        axr(a);
        chk(rd, exp);
    endtask

    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Timeout and test sequence
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        ext_lvl <= 8'h3c;
        rchk(EGP_ADDR_DIR, 32'h0);
        chk({24'h0, pin_oe}, 32'h0);
        // Latch written while input, before any pin turns output
        axw(EGP_ADDR_LATCH, 32'ha5, 4'hf);
        repeat (8) @(posedge core_clk);
        rchk(EGP_ADDR_LATCH, 32'h3c);
        axw(EGP_ADDR_DIR, 32'h0f, 4'hf);
        chk({30'h0, rsp}, {30'h0, EGP_RESP_OKAY});
        repeat (8) @(posedge core_clk);
        chk({24'h0, pin_oe}, 32'h0f);
        chk({24'h0, pin_out}, 32'h05);
        rchk(EGP_ADDR_DIR, 32'h0f);
        rchk(EGP_ADDR_LATCH, 32'h35);
        // Empty strobe must leave the latch alone
        axw(EGP_ADDR_LATCH, 32'h5a, 4'h0);
        axw(EGP_ADDR_DIR, 32'hff, 4'hf);
        rchk(EGP_ADDR_LATCH, 32'ha5);
        axw(EGP_ADDR_LATCH, 32'h5a, 4'hf);
        rchk(EGP_ADDR_LATCH, 32'h5a);
        axw(EGP_ADDR_ADC, 32'h0c, 4'hf);
        rchk(EGP_ADDR_ADC, 32'h0c);
        repeat (2) @(posedge core_clk);
        chk({24'h0, analog_sel}, 32'h10);
        chk({24'h0, pin_oe}, 32'hef);
        chk({24'h0, pin_out}, 32'h4a);
        rchk(EGP_ADDR_LATCH, 32'h5a);
        // Enable bit clear: pin number alone selects nothing
        axw(EGP_ADDR_ADC, 32'h04, 4'hf);
        rchk(EGP_ADDR_ADC, 32'h04);
        repeat (2) @(posedge core_clk);
        chk({16'h0, analog_sel, pin_oe}, 32'h00ff);
        rchk(14'h0000, 32'h0);
        chk({30'h0, rsp}, {30'h0, EGP_RESP_SLVERR});
        axw(14'h0010, 32'hff, 4'hf);
        chk({30'h0, rsp}, {30'h0, EGP_RESP_SLVERR});
        // Second reset mid-run: direction clears, latch survives
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rchk(EGP_ADDR_DIR, 32'h0);
        chk({24'h0, pin_oe}, 32'h0);
        axw(EGP_ADDR_DIR, 32'hff, 4'hf);
        rchk(EGP_ADDR_LATCH, 32'h5a);
        end_of_test();
    end
endmodule
